// *** test/mbxtm_chk.sv ***
`timescale 1ns/1ps
// Watches the request and answer ports of the type mapper.
module mbxtm_chk (
   // Clock and reset
   input wire clk,
   input wire nrst,
   // Request side
   input wire req_valid,
   input wire req_ready,
   input wire [7:0] req_func,
   input wire [15:0] req_addr,
   input wire [15:0] req_count,
   // Answers
   input wire exc_valid,
   input wire [7:0] exc_func,
   input wire [7:0] exc_code,
   input wire rd_word_valid,
   input wire rd_word_ready,
   input wire [15:0] rd_word,
   input wire param_rd_en,
   input wire param_wr_en
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // A request is taken on an edge where both halves of the handshake are high.
   wire take = req_valid && req_ready;
   exc_flag_a: assert property (
      take ##1 exc_valid |-> exc_func == ($past(req_func) | 8'h80))
      else $error("Exception function code wrong.");
   rsvd_type_a: assert property (
      take && req_func == 8'h03 && req_addr[15:14] == 2'b11 |=> exc_valid && exc_code == 8'h02)
      else $error("Reserved type not refused.");
   odd_count_a: assert property (
      take && req_func == 8'h03 && req_addr[15:14] == 2'b01 && req_count[0]
      |=> exc_valid && exc_code == 8'h02) else $error("Odd count not refused.");
   bad_func_a: assert property (
      take && !(req_func inside {8'h03, 8'h06, 8'h10, 8'h17}) |=> exc_valid && exc_code == 8'h01)
      else $error("Unknown function not refused.");
   single_wide_a: assert property (
      take && req_func == 8'h06 && req_addr[15:14] != 2'b00 |=> exc_valid && exc_code == 8'h02)
      else $error("Wide single write not refused.");
   exc_nodata_a: assert property (
      exc_valid |-> !param_rd_en && !param_wr_en && !rd_word_valid)
      else $error("Data moved with an exception.");
   block_busy_a: assert property (
      take |=> exc_valid || !req_ready) else $error("Request taken during a block.");
   word_hold_a: assert property (
      rd_word_valid && !rd_word_ready |=> rd_word_valid && $stable(rd_word))
      else $error("Read word changed while stalled.");
endmodule // mbxtm_chk

bind mbxtm_mapper mbxtm_chk u_chk (.*);

// *** test/mbxtm_store.sv ***
`timescale 1ns/1ps
// Parameter store seen by the mapper; eight entries keyed by the low index bits.
module mbxtm_store (
   // Clock
   input wire clk,
   // Access from the mapper
   input wire param_rd_en,
   input wire param_wr_en,
   input wire [13:0] param_index,
   input wire [31:0] param_wr_data,
   // Read answer
   output reg [31:0] param_rd_data,
   output reg param_is32
);
   reg [31:0] mem [0:7];
   reg [7:0] w32;
   // Sample contents: entry 7 is a wide value, entries 0 and 1 are narrow.
   initial begin
      mem[7] = 32'h12345678;
      mem[0] = 32'h0000abcd;
      mem[1] = 32'h00000123;
      w32 = 8'h80;
      param_rd_data = 32'h00000000;
      param_is32 = 1'b0;
   end
   // Answer one cycle after the strobe; scramble otherwise so stale data never passes.
   always @(posedge clk) begin
      if (param_rd_en) begin
         param_rd_data <= mem[param_index[2:0]];
         param_is32 <= w32[param_index[2:0]];
      end else begin
         param_rd_data <= ~param_rd_data;
         param_is32 <= ~param_is32;
      end
      if (param_wr_en) mem[param_index[2:0]] <= param_wr_data;
   end
endmodule // mbxtm_store

// *** test/tb_top.sv ***
`timescale 1ns/1ps
// Directed bench for the type mapper against a small parameter store.
module tb_top;
   reg clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_write = 1'b0;
   reg rd_word_ready = 1'b0, wr_word_valid = 1'b0;
   reg [7:0] req_func = 8'h00;
   reg [15:0] req_addr = 16'h0000, req_count = 16'h0000, wr_word = 16'h0000;
   wire req_ready, exc_valid, rd_word_valid, wr_word_ready, done;
   wire param_rd_en, param_wr_en, param_is32;
   wire [7:0] exc_func, exc_code;
   wire [15:0] rd_word, done_count;
   wire [13:0] param_index;
   wire [31:0] param_wr_data, param_rd_data;
   integer fails = 0, comparisons = 0, cyc = 0;
   mbxtm_mapper u_mbxtm_mapper (.*);
   // Second mapper without float support; it shares the stimulus and runs in step with the first except on float requests, which it refuses.
   wire nf_exc_valid;
   wire [7:0] nf_exc_code;
   mbxtm_mapper #(.FLOAT_EN(0)) u_mbxtm_mapper_nf (
      .clk(clk), .nrst(nrst), .req_valid(req_valid), .req_func(req_func),
      .req_write(req_write), .req_addr(req_addr), .req_count(req_count), .req_ready(),
      .exc_valid(nf_exc_valid), .exc_func(), .exc_code(nf_exc_code),
      .rd_word_valid(), .rd_word(), .rd_word_ready(rd_word_ready),
      .wr_word_valid(wr_word_valid), .wr_word(wr_word), .wr_word_ready(),
      .param_rd_en(), .param_wr_en(), .param_index(), .param_wr_data(),
      .param_rd_data(param_rd_data), .param_is32(param_is32), .done(), .done_count());
   mbxtm_store u_mbxtm_store (.*);
   // Clock at 125 MHz.
   always #4 clk = ~clk;
   // Watchdog; the run needs well under 3000 cycles.
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         fails = fails + 1;
         summarize;
      end
   end
   task chk(input [8*10:1] name, input [31:0] exp, input [31:0] got);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("Error %0s expected %h seen %h", name, exp, got);
      end
   endtask
   task summarize;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Present a request and hold it until the edge that takes it.
   task req(input [7:0] f, input [15:0] a, input [15:0] n);
      @(negedge clk);
      req_func = f;
      req_addr = a;
      req_count = n;
      req_valid = 1'b1;
      while (req_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
      req_valid = 1'b0;
   endtask
   // Stall each word one edge before taking it, so the hold is exercised.
   task get(input [15:0] exp);
      while (rd_word_valid !== 1'b1) @(negedge clk);
      @(negedge clk);
      chk("read word", {16'h0000, exp}, {16'h0000, rd_word});
      rd_word_ready = 1'b1;
      @(negedge clk);
      rd_word_ready = 1'b0;
   endtask
   task put(input [15:0] w);
      wr_word = w;
      wr_word_valid = 1'b1;
      while (wr_word_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
   endtask
   task fin(input [15:0] n);
      wr_word_valid = 1'b0;
      while (done !== 1'b1) @(negedge clk);
      chk("word count", {16'h0000, n}, {16'h0000, done_count});
   endtask
   task exc(input [7:0] f, input [15:0] a, input [15:0] n, input [7:0] c);
      req(f, a, n);
      // The pulse stands until the next edge, so it is looked at straight after the take.
      chk("exc valid", 32'h00000001, {31'h0, exc_valid});
      chk("exc code", {24'h000000, c}, {24'h000000, exc_code});
      chk("exc func", {24'h000000, f | 8'h80}, {24'h000000, exc_func});
   endtask
   task t_rd16;
      req(8'h03, 16'd127, 16'd2);
      get(16'h5678);
      get(16'habcd);
      fin(16'd2);
      $display("test narrow read done");
   endtask
   task t_rd32;
      req(8'h03, 16'd16511, 16'd4);
      get(16'h1234);
      get(16'h5678);
      get(16'hffff);
      get(16'habcd);
      fin(16'd4);
      req(8'h03, 16'h807f, 16'd2);
      chk("float off", 32'h00000001, {31'h0, nf_exc_valid});
      chk("float code", 32'h00000002, {24'h000000, nf_exc_code});
      get(16'h1234);
      get(16'h5678);
      fin(16'd2);
      $display("test wide read done");
   endtask
   task t_wr;
      req(8'h06, 16'd127, 16'd1);
      put(16'habcd);
      fin(16'd1);
      chk("stored 7", 32'hffffabcd, u_mbxtm_store.mem[7]);
      req(8'h10, 16'd16512, 16'd2);
      put(16'h0000);
      put(16'h0123);
      fin(16'd2);
      chk("stored 0", 32'h00000123, u_mbxtm_store.mem[0]);
      $display("test writes done");
   endtask
   task t_exc;
      exc(8'h03, 16'h407f, 16'd1, 8'h02);
      exc(8'h03, 16'hc07f, 16'd2, 8'h02);
      exc(8'h04, 16'd127, 16'd1, 8'h01);
      exc(8'h06, 16'h407f, 16'd1, 8'h02);
      exc(8'h03, 16'h0000, 16'd0, 8'h02);
      exc(8'h03, 16'h0000, 16'd126, 8'h02);
      exc(8'h10, 16'h3fff, 16'd2, 8'h02);
      $display("test exceptions done");
   endtask
   // Combined service: write half first, then the read half as a wide access.
   task t_rw;
      req_write = 1'b1;
      req(8'h17, 16'd128, 16'd1);
      put(16'h8001);
      fin(16'd1);
      chk("stored 0", 32'hffff8001, u_mbxtm_store.mem[0]);
      req_write = 1'b0;
      req(8'h17, 16'h4080, 16'd2);
      get(16'hffff);
      get(16'h8001);
      fin(16'd2);
      $display("test read write done");
   endtask
   // Reset in the middle of a block must abort it and bring ready back.
   task t_rst;
      req(8'h03, 16'd127, 16'd1);
      nrst = 1'b0;
      @(negedge clk);
      chk("ready rst", 32'h00000000, {31'h0, req_ready});
      nrst = 1'b1;
      @(negedge clk);
      chk("ready up", 32'h00000001, {31'h0, req_ready});
      @(negedge clk);
      chk("valid rst", 32'h00000000, {31'h0, rd_word_valid});
      chk("done rst", 32'h00000000, {31'h0, done});
      $display("test reset done");
   endtask
   // Reset for ten cycles, then run every scenario.
   initial begin
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      t_rd16;
      t_rd32;
      t_wr;
      t_exc;
      t_rw;
      t_rst;
      summarize;
   end
endmodule // tb_top

// *** verilog/mbxtm_convert.v ***
`timescale 1ns/1ps

// Width adaptation of a stored parameter to the selected access width.
module mbxtm_convert (
   // Stored value and its native width
   input wire stored_is32,
   input wire [31:0] raw,
   // Selected access width
   input wire sel32,
   // Value as it is to be sent
   output reg [31:0] value
);

   always @* begin
      if (!sel32) begin
         value = {16'h0000, raw[15:0]};
      end else if (stored_is32) begin
         value = raw;
      end else begin
         value = {{16{raw[15]}}, raw[15:0]};
      end
   end

endmodule // mbxtm_convert

// *** verilog/mbxtm_defs.vh ***
`ifndef MBXTM_DEFS_VH
`define MBXTM_DEFS_VH

// Field positions inside a 16-bit register address.
`define MBXTM_TYPE_HI_BIT 15
`define MBXTM_TYPE_LO_BIT 14
`define MBXTM_INDEX_MSB 13

// Data type selector codes.
`define MBXTM_TYPE_INT16 2'b00
`define MBXTM_TYPE_INT32 2'b01
`define MBXTM_TYPE_FLOAT 2'b10
`define MBXTM_TYPE_RSVD 2'b11

// Function codes handled by the mapper.
`define MBXTM_FC_READ_MULTI 8'h03
`define MBXTM_FC_WRITE_SINGLE 8'h06
`define MBXTM_FC_WRITE_MULTI 8'h10
`define MBXTM_FC_READ_WRITE 8'h17

// Exception reply fields.
`define MBXTM_FC_EXC_FLAG 8'h80
`define MBXTM_EXC_BAD_FUNC 8'h01
`define MBXTM_EXC_BAD_ADDR 8'h02

// Default values of the mapper limits.
`define MBXTM_MAX_REGS_DEF 16'h007d
`define MBXTM_PARAM_COUNT_DEF 17'h04000

`endif

// *** verilog/mbxtm_mapper.v ***
// Functional notes
// - Top two address bits select type.
// - Low fourteen bits are parameter index.
// - 00 int16, 01 int32, 10 float, 11 reserved.
// - Start address type applies to whole block.
// - 32-bit values use two words, high first.
// - 32-bit only through multiple register services.
// - 32-bit stored, 16-bit read returns low word.
// - 16-bit stored, 32-bit read sign-extends.
// - Odd count with 32-bit type gives exception 2.
// - Float is IEEE single, support optional.
// - Exception carries function code with bit 7.
// - Code 2 bad address, code 1 bad function.
// - 16-bit write to 32-bit parameter sign-extends.
`timescale 1ns/1ps
`include "mbxtm_defs.vh"

module mbxtm_mapper #(
   parameter FLOAT_EN = 1,
   parameter [15:0] MAX_REGS = `MBXTM_MAX_REGS_DEF,
   parameter [16:0] PARAM_COUNT = `MBXTM_PARAM_COUNT_DEF
) (
   // Clock and reset
   input wire clk,
   input wire nrst,
   // Decoded request from the frame handler
   input wire req_valid,
   input wire [7:0] req_func,
   input wire req_write,
   input wire [15:0] req_addr,
   input wire [15:0] req_count,
   output reg req_ready,
   // Exception answer
   output reg exc_valid,
   output reg [7:0] exc_func,
   output reg [7:0] exc_code,
   // Read data words towards the frame handler
   output reg rd_word_valid,
   output reg [15:0] rd_word,
   input wire rd_word_ready,
   // Write data words from the frame handler
   input wire wr_word_valid,
   input wire [15:0] wr_word,
   output reg wr_word_ready,
   // Parameter store
   output reg param_rd_en,
   output reg param_wr_en,
   output reg [13:0] param_index,
   output reg [31:0] param_wr_data,
   input wire [31:0] param_rd_data,
   input wire param_is32,
   // Completion
   output reg done,
   output reg [15:0] done_count
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_FETCH = 3'h1;
   localparam [2:0] ST_LOAD = 3'h2;
   localparam [2:0] ST_SEND_HI = 3'h3;
   localparam [2:0] ST_SEND_LO = 3'h4;
   localparam [2:0] ST_WR_HI = 3'h5;
   localparam [2:0] ST_WR_LO = 3'h6;
   localparam [2:0] ST_STORE = 3'h7;

   // Sign extension of a 16-bit word to the full store width.
   function [31:0] sext16;
      input [15:0] w;
      begin
         sext16 = {{16{w[15]}}, w};
      end
   endfunction

   reg [2:0] state;
   reg sel32;
   reg [13:0] cur_index;
   reg [15:0] remaining;
   reg [15:0] words_done;
   reg [15:0] wr_hi;
   reg [31:0] rd_value;

   wire [31:0] conv_value;
   wire [1:0] req_type;
   wire req_sel32;
   wire req_func_ok;
   wire req_is_write;
   wire [15:0] req_params;
   wire [16:0] req_end;
   wire req_bad_addr;
   wire is_last;

   assign req_type = {req_addr[`MBXTM_TYPE_HI_BIT], req_addr[`MBXTM_TYPE_LO_BIT]};
   // any non-zero type is a 32-bit access.
   assign req_sel32 = (req_type != `MBXTM_TYPE_INT16);
   assign req_func_ok = (req_func == `MBXTM_FC_READ_MULTI) ||
                        (req_func == `MBXTM_FC_WRITE_SINGLE) ||
                        (req_func == `MBXTM_FC_WRITE_MULTI) ||
                        (req_func == `MBXTM_FC_READ_WRITE);
   assign req_is_write = (req_func == `MBXTM_FC_WRITE_SINGLE) ||
                         (req_func == `MBXTM_FC_WRITE_MULTI) ||
                         ((req_func == `MBXTM_FC_READ_WRITE) && req_write);
   // count is taken as word pairs for 32-bit access.
   assign req_params = req_sel32 ? {1'b0, req_count[15:1]} : req_count;
   // index range check on the whole block.
   assign req_end = {3'b000, req_addr[`MBXTM_INDEX_MSB:0]} + {1'b0, req_params};

   // Address class errors answer with code 2 unless the function is also unknown, which answers code 1; the far end cannot tell them apart.
   // odd count rejected for 32-bit types.
   assign req_bad_addr = (req_type == `MBXTM_TYPE_RSVD) ||
                         ((req_type == `MBXTM_TYPE_FLOAT) && (FLOAT_EN == 0)) ||
                         (req_sel32 && req_count[0]) ||
                         (req_count == 16'h0000) ||
                         (req_count > MAX_REGS) ||
                         ((req_func == `MBXTM_FC_WRITE_SINGLE) &&
                          (req_sel32 || (req_count != 16'h0001))) ||
                         (req_end > PARAM_COUNT);

   assign is_last = (remaining == 16'h0001);

   mbxtm_convert u_convert (
      .stored_is32(param_is32),
      .raw(param_rd_data),
      .sel32(sel32),
      .value(conv_value)
   );

   // Request sequencer; all outputs are registered here.
   always @(posedge clk) begin
      if (!nrst) begin
         state <= ST_IDLE;
         sel32 <= 1'b0;
         cur_index <= 14'h0000;
         remaining <= 16'h0000;
         words_done <= 16'h0000;
         wr_hi <= 16'h0000;
         rd_value <= 32'h00000000;
         req_ready <= 1'b0;
         exc_valid <= 1'b0;
         exc_func <= 8'h00;
         exc_code <= 8'h00;
         rd_word_valid <= 1'b0;
         rd_word <= 16'h0000;
         wr_word_ready <= 1'b0;
         param_rd_en <= 1'b0;
         param_wr_en <= 1'b0;
         param_index <= 14'h0000;
         param_wr_data <= 32'h00000000;
         done <= 1'b0;
         done_count <= 16'h0000;
      end else begin
         exc_valid <= 1'b0;
         done <= 1'b0;
         param_rd_en <= 1'b0;
         param_wr_en <= 1'b0;
         case (state)
            ST_IDLE: begin
               req_ready <= 1'b1;
               if (req_valid && req_ready) begin
                  if (!req_func_ok || req_bad_addr) begin
                     // function code with bit 7 set.
                     exc_valid <= 1'b1;
                     exc_func <= req_func | `MBXTM_FC_EXC_FLAG;
                     exc_code <= req_func_ok ? `MBXTM_EXC_BAD_ADDR : `MBXTM_EXC_BAD_FUNC;
                  end else begin
                     req_ready <= 1'b0;
                     sel32 <= req_sel32;
                     cur_index <= req_addr[`MBXTM_INDEX_MSB:0];
                     remaining <= req_params;
                     words_done <= 16'h0000;
                     if (req_is_write) begin
                        wr_word_ready <= 1'b1;
                        state <= req_sel32 ? ST_WR_HI : ST_WR_LO;
                     end else begin
                        state <= ST_FETCH;
                     end
                  end
               end
            end
            ST_FETCH: begin
               param_rd_en <= 1'b1;
               param_index <= cur_index;
               state <= ST_LOAD;
            end
            ST_LOAD: begin
               // Store answers one cycle after the strobe, so sample here.
               if (!param_rd_en) begin
                  rd_value <= conv_value;
                  rd_word_valid <= 1'b1;
                  // float words pass as raw IEEE bits.
                  rd_word <= sel32 ? conv_value[31:16] : conv_value[15:0];
                  state <= sel32 ? ST_SEND_HI : ST_SEND_LO;
               end
            end
            ST_SEND_HI: begin
               if (rd_word_ready) begin
                  rd_word <= rd_value[15:0];
                  words_done <= words_done + 16'h0001;
                  state <= ST_SEND_LO;
               end
            end
            ST_SEND_LO: begin
               if (rd_word_ready) begin
                  rd_word_valid <= 1'b0;
                  words_done <= words_done + 16'h0001;
                  remaining <= remaining - 16'h0001;
                  cur_index <= cur_index + 14'h0001;
                  if (is_last) begin
                     done <= 1'b1;
                     done_count <= words_done + 16'h0001;
                     state <= ST_IDLE;
                  end else begin
                     state <= ST_FETCH;
                  end
               end
            end
            ST_WR_HI: begin
               if (wr_word_valid) begin
                  wr_hi <= wr_word;
                  words_done <= words_done + 16'h0001;
                  state <= ST_WR_LO;
               end
            end
            ST_WR_LO: begin
               if (wr_word_valid) begin
                  // Ready drops while the store is written, stalling the source.
                  wr_word_ready <= 1'b0;
                  words_done <= words_done + 16'h0001;
                  param_wr_en <= 1'b1;
                  param_index <= cur_index;
                  param_wr_data <= sel32 ? {wr_hi, wr_word} : sext16(wr_word);
                  state <= ST_STORE;
               end
            end
            ST_STORE: begin
               remaining <= remaining - 16'h0001;
               cur_index <= cur_index + 14'h0001;
               if (is_last) begin
                  done <= 1'b1;
                  done_count <= words_done;
                  state <= ST_IDLE;
               end else begin
                  wr_word_ready <= 1'b1;
                  state <= sel32 ? ST_WR_HI : ST_WR_LO;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // mbxtm_mapper
